// *** rtl/pwr_defines.svh ***
// Field positions, reset values and timing counts for the power and wake controller
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH

// Power mode field inside the control byte
`define MODE_LSB 3
`define MODE_MSB 4
`define MODE_RESET 2'b00
`define MODE_RESERVED 2'b11

// Clock period and derived counts
`define CLK_PERIOD_NS 8
`define US_NS 1000
`define US_CYC (`US_NS / `CLK_PERIOD_NS)
`define ENERGY_PRESENT_NS 100
`define ENERGY_PRESENT_CYC ((`ENERGY_PRESENT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_NS 20000000
`define REFRESH_PERIOD_CYC ((`REFRESH_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_LEN_NS 200000
`define REFRESH_LEN_CYC ((`REFRESH_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RX_CLK_STOP_CYC 9
`define LINK_PULSE_NS 16000000
`define LINK_PULSE_CYC (`LINK_PULSE_NS / `CLK_PERIOD_NS)
`define LINK_PULSE_LEN_NS 100
`define LINK_PULSE_LEN_CYC ((`LINK_PULSE_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE 2'd2

// Wake packet layout
`define SYNC_BYTE 8'hff
`define WAKE_SYNC_BYTES 3'd6
`define WAKE_LAST_POS 3'd5
`define WAKE_LAST_REP 4'hf
`define DA_BYTES 3'd6

`endif

// *** rtl/pwr_pkg.sv ***
// Types shared by the power and wake controller
package pwr_pkg;
	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_ENERGY_DETECT_POWERDOWN = 2'b01,
		PM_SOFT_PD = 2'b10
	} pwr_mode_t;

	typedef enum logic {
		ED_FULL = 1'b0,
		ED_LOW = 1'b1
	} energy_detect_powerdown_state_t;

	typedef enum logic [1:0] {
		TX_ACTIVE = 2'b00,
		TX_QUIET = 2'b01,
		TX_REFRESH = 2'b10
	} tx_lpi_state_t;

	typedef struct packed {
		logic sof;
		logic valid;
		logic [7:0] data;
	} rx_byte_t;

	typedef struct packed {
		logic pkt;
		logic link_up;
		logic energy;
	} wake_evt_t;

	// Byte idx of a MAC address, most significant first
	function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [2:0] idx);
		logic [47:0] s;
		s = mac << (idx * 8);
		mac_byte = s[47:40];
	endfunction : mac_byte
endpackage : pwr_pkg

// *** rtl/wake_pkt_matcher.sv ***
// Wake packet sequence matcher over a received byte stream
`timescale 1ns/1ps
`include "pwr_defines.svh"
module wake_pkt_matcher import pwr_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic scan_en_in,
	input wire rx_byte_t rx_in,
	input wire logic [47:0] node_mac_in,
	output logic hit_out
);
	logic [2:0] sync_reg, sync_next;
	logic [2:0] pos_reg, pos_next;
	logic [3:0] rep_reg, rep_next;
	logic hit_reg, hit_next;
	logic is_ff;

	assign is_ff = (rx_in.data == `SYNC_BYTE);

	// Sync count, then sixteen unbroken address copies
	always_comb begin
		sync_next = sync_reg;
		pos_next = pos_reg;
		rep_next = rep_reg;
		hit_next = 1'b0;
		if (rx_in.sof) begin
			sync_next = 3'd0;
			pos_next = 3'd0;
			rep_next = 4'h0;
		end
		if (scan_en_in && rx_in.valid) begin
			if (sync_next != `WAKE_SYNC_BYTES) begin
				sync_next = is_ff ? sync_next + 3'd1 : 3'd0;
			end else if (rx_in.data == mac_byte(node_mac_in, pos_next)) begin
				if (pos_next == `WAKE_LAST_POS) begin
					pos_next = 3'd0;
					if (rep_next == `WAKE_LAST_REP) begin
						hit_next = 1'b1;
						sync_next = 3'd0;
						rep_next = 4'h0;
					end else begin
						rep_next = rep_next + 4'h1;
					end
				end else begin
					pos_next = pos_next + 3'd1;
				end
			end else if (is_ff && pos_next == 3'd0 && rep_next == 4'h0) begin
				sync_next = `WAKE_SYNC_BYTES; // Extra sync bytes keep the lock
			end else begin
				sync_next = is_ff ? 3'd1 : 3'd0;
				pos_next = 3'd0;
				rep_next = 4'h0;
			end
		end
	end

	// Matcher state registers
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync_reg <= 3'd0;
			pos_reg <= 3'd0;
			rep_reg <= 4'h0;
			hit_reg <= 1'b0;
		end else begin
			sync_reg <= sync_next;
			pos_reg <= pos_next;
			rep_reg <= rep_next;
			hit_reg <= hit_next;
		end
	end

	assign hit_out = hit_reg;
endmodule : wake_pkt_matcher

// *** rtl/switch_power_mgmt_wake.sv ***
// Global power modes, per-port power down, EEE low-power idle and wake event reporting
`timescale 1ns/1ps
`include "pwr_defines.svh"
module switch_power_mgmt_wake import pwr_pkg::*; #(
	parameter int PORTS = 7,
	parameter int EEE_PORTS = 5,
	parameter int STRAP_W = 8,
	parameter int REFRESH_PERIOD_CYC = `REFRESH_PERIOD_CYC,
	parameter int REFRESH_LEN_CYC = `REFRESH_LEN_CYC,
	parameter int LINK_PULSE_CYC = `LINK_PULSE_CYC
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic ctrl_wr_in,
	input wire logic [7:0] ctrl_wdata_in,
	input wire logic [15:0] quiet_us_in,
	input wire logic [15:0] wake_energy_cyc_in,
	input wire logic [EEE_PORTS-1:0] cable_energy_in,
	input wire logic [EEE_PORTS-1:0] link_up_in,
	input wire logic [PORTS-1:0] port_pwrdn_in,
	input wire logic [EEE_PORTS-1:0] eee_en_in,
	input wire logic [EEE_PORTS-1:0] an_eee_ok_in,
	input wire logic [EEE_PORTS-1:0] mac_tx_lpi_req_in,
	input wire logic [EEE_PORTS-1:0] rx_code_valid_in,
	input wire logic [EEE_PORTS-1:0] rx_pcode_in,
	input wire rx_byte_t rx_byte_in,
	input wire logic [47:0] node_mac_in,
	input wire wake_evt_t wake_en_in,
	input wire wake_evt_t wake_clr_in,
	input wire logic pme_en_in,
	input wire logic int_en_in,
	input wire logic [STRAP_W-1:0] strap_in,
	output pwr_mode_t mode_out,
	output logic energy_detect_powerdown_low_out,
	output logic pll_en_out,
	output logic mac_en_out,
	output logic energy_det_en_out,
	output logic [PORTS-1:0] port_en_out,
	output logic link_pulse_out,
	output logic soft_reset_out,
	output logic [STRAP_W-1:0] strap_out,
	output logic [EEE_PORTS-1:0] eee_active_out,
	output logic [EEE_PORTS-1:0] tx_lpi_out,
	output logic [EEE_PORTS-1:0] tx_refresh_out,
	output logic [EEE_PORTS-1:0] rx_lpi_out,
	output logic [EEE_PORTS-1:0] rx_clk_stop_out,
	output wake_evt_t wake_status_out,
	output logic power_event_out_n,
	output logic host_interrupt_out_n
);
	localparam int RW = $clog2(REFRESH_PERIOD_CYC + 1);
	localparam int PW = $clog2(LINK_PULSE_CYC + 1);

	// Two-stage synchronisers for cable energy and straps
	logic [EEE_PORTS-1:0] energy_s1_reg, energy_s2_reg;
	logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg;
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			energy_s1_reg <= '0;
			energy_s2_reg <= '0;
			strap_s1_reg <= '0;
			strap_s2_reg <= '0;
		end else begin
			energy_s1_reg <= cable_energy_in;
			energy_s2_reg <= energy_s1_reg;
			strap_s1_reg <= strap_in;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// Global mode, energy-detect substate, timers and strap capture
	pwr_mode_t mode_reg, mode_next;
	energy_detect_powerdown_state_t ed_reg, ed_next;
	logic [6:0] us_pre_reg, us_pre_next;
	logic [15:0] quiet_reg, quiet_next;
	logic [15:0] run_reg, run_next;
	logic [PW-1:0] pulse_reg, pulse_next;
	logic [1:0] settle_reg, settle_next;
	logic strap_done_reg, strap_done_next;
	logic [STRAP_W-1:0] strap_reg, strap_next;
	logic soft_rst_reg, soft_rst_next;
	logic [1:0] wr_field;
	logic wr_ok, soft_exit, any_energy, us_tick;

	assign wr_field = ctrl_wdata_in[`MODE_MSB:`MODE_LSB];
	assign wr_ok = ctrl_wr_in && (wr_field != `MODE_RESERVED);
	assign soft_exit = wr_ok && (mode_reg == PM_SOFT_PD) && (wr_field != PM_SOFT_PD);
	assign any_energy = |energy_s2_reg;
	assign us_tick = (us_pre_reg == 7'(`US_CYC - 1));

	always_comb begin
		mode_next = mode_reg;
		ed_next = ed_reg;
		us_pre_next = us_tick ? 7'd0 : us_pre_reg + 7'd1;
		quiet_next = quiet_reg;
		run_next = any_energy ? ((run_reg == 16'hffff) ? run_reg : run_reg + 16'h1) : 16'h0;
		pulse_next = '0;
		settle_next = (settle_reg != 2'd0) ? settle_reg - 2'd1 : settle_reg;
		strap_done_next = strap_done_reg;
		strap_next = strap_reg;
		soft_rst_next = soft_exit;
		if (soft_exit) begin
			mode_next = pwr_mode_t'(`MODE_RESET);
		end else if (wr_ok) begin
			mode_next = pwr_mode_t'(wr_field);
		end
		if ((settle_reg == 2'd0 && !strap_done_reg) || soft_exit) begin
			strap_next = strap_s2_reg;
			strap_done_next = 1'b1;
		end
		if (any_energy) begin
			quiet_next = 16'h0;
		end else if (us_tick && quiet_reg != 16'hffff) begin
			quiet_next = quiet_reg + 16'h1;
		end
		case (ed_reg)
			ED_FULL: begin
				if (mode_reg == PM_ENERGY_DETECT_POWERDOWN && quiet_reg > quiet_us_in) begin
					ed_next = ED_LOW;
				end
			end
			ED_LOW: begin
				if (pulse_reg != PW'(LINK_PULSE_CYC - 1)) begin
					pulse_next = pulse_reg + 1'b1;
				end
				if (run_reg >= 16'(`ENERGY_PRESENT_CYC)) begin
					ed_next = ED_FULL;
				end
			end
			default: begin
				ed_next = ED_FULL;
			end
		endcase
		if (mode_next != PM_ENERGY_DETECT_POWERDOWN) begin
			ed_next = ED_FULL;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_reg <= pwr_mode_t'(`MODE_RESET);
			ed_reg <= ED_FULL;
			us_pre_reg <= 7'd0;
			quiet_reg <= 16'h0;
			run_reg <= 16'h0;
			pulse_reg <= '0;
			settle_reg <= `STRAP_SETTLE;
			strap_done_reg <= 1'b0;
			strap_reg <= '0;
			soft_rst_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			ed_reg <= ed_next;
			us_pre_reg <= us_pre_next;
			quiet_reg <= quiet_next;
			run_reg <= run_next;
			pulse_reg <= pulse_next;
			settle_reg <= settle_next;
			strap_done_reg <= strap_done_next;
			strap_reg <= strap_next;
			soft_rst_reg <= soft_rst_next;
		end
	end

	// Block enables per mode and per port
	logic phy_on, normal;
	assign normal = (mode_reg == PM_NORMAL);
	assign phy_on = normal || (mode_reg == PM_ENERGY_DETECT_POWERDOWN && ed_reg == ED_FULL);
	assign mode_out = mode_reg;
	assign energy_detect_powerdown_low_out = (ed_reg == ED_LOW);
	assign pll_en_out = normal;
	assign mac_en_out = normal;
	assign energy_det_en_out = (mode_reg == PM_ENERGY_DETECT_POWERDOWN);
	assign link_pulse_out = (ed_reg == ED_LOW) && (pulse_reg < PW'(`LINK_PULSE_LEN_CYC));
	assign port_en_out = {PORTS{phy_on}} & ~port_pwrdn_in;
	assign soft_reset_out = soft_rst_reg;
	assign strap_out = strap_reg;

	// EEE on PHY ports only
	logic [EEE_PORTS-1:0] eee_act;
	assign eee_act = eee_en_in & an_eee_ok_in & {EEE_PORTS{normal}}
		& ~port_pwrdn_in[EEE_PORTS-1:0];
	assign eee_active_out = eee_act;

	// Transmit idle and refresh timing, one machine per port
	tx_lpi_state_t tx_reg [EEE_PORTS];
	tx_lpi_state_t tx_next [EEE_PORTS];
	logic [RW-1:0] tx_cnt_reg [EEE_PORTS];
	logic [RW-1:0] tx_cnt_next [EEE_PORTS];
	always_comb begin
		for (int i = 0; i < EEE_PORTS; i++) begin
			tx_next[i] = tx_reg[i];
			tx_cnt_next[i] = tx_cnt_reg[i] + 1'b1;
			case (tx_reg[i])
				TX_ACTIVE: begin
					tx_cnt_next[i] = '0;
					if (eee_act[i] && mac_tx_lpi_req_in[i]) begin
						tx_next[i] = TX_QUIET;
					end
				end
				TX_QUIET: begin
					if (!(eee_act[i] && mac_tx_lpi_req_in[i])) begin
						tx_next[i] = TX_ACTIVE;
					end else if (tx_cnt_reg[i] == RW'(REFRESH_PERIOD_CYC - 1)) begin
						tx_next[i] = TX_REFRESH;
						tx_cnt_next[i] = '0;
					end
				end
				TX_REFRESH: begin
					if (!(eee_act[i] && mac_tx_lpi_req_in[i])) begin
						tx_next[i] = TX_ACTIVE;
					end else if (tx_cnt_reg[i] == RW'(REFRESH_LEN_CYC - 1)) begin
						tx_next[i] = TX_QUIET;
						tx_cnt_next[i] = '0;
					end
				end
				default: begin
					tx_next[i] = TX_ACTIVE;
				end
			endcase
			if (tx_next[i] == TX_ACTIVE) begin
				tx_cnt_next[i] = '0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < EEE_PORTS; i++) begin
				tx_reg[i] <= TX_ACTIVE;
				tx_cnt_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < EEE_PORTS; i++) begin
				tx_reg[i] <= tx_next[i];
				tx_cnt_reg[i] <= tx_cnt_next[i];
			end
		end
	end

	// Receive idle tracking, independent of transmit
	logic [EEE_PORTS-1:0] rx_lpi_reg, rx_lpi_next;
	logic [3:0] rx_cnt_reg [EEE_PORTS];
	logic [3:0] rx_cnt_next [EEE_PORTS];
	always_comb begin
		for (int i = 0; i < EEE_PORTS; i++) begin
			rx_lpi_next[i] = rx_lpi_reg[i];
			if (!eee_act[i]) begin
				rx_lpi_next[i] = 1'b0;
			end else if (rx_code_valid_in[i]) begin
				rx_lpi_next[i] = rx_pcode_in[i];
			end
			if (!rx_lpi_reg[i] || !rx_lpi_next[i]) begin
				rx_cnt_next[i] = 4'h0;
			end else if (rx_cnt_reg[i] != 4'(`RX_CLK_STOP_CYC)) begin
				rx_cnt_next[i] = rx_cnt_reg[i] + 4'h1;
			end else begin
				rx_cnt_next[i] = rx_cnt_reg[i];
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_lpi_reg <= '0;
			for (int i = 0; i < EEE_PORTS; i++) begin
				rx_cnt_reg[i] <= 4'h0;
			end
		end else begin
			rx_lpi_reg <= rx_lpi_next;
			for (int i = 0; i < EEE_PORTS; i++) begin
				rx_cnt_reg[i] <= rx_cnt_next[i];
			end
		end
	end

	// Transmit and receive idle indications
	always_comb begin
		for (int i = 0; i < EEE_PORTS; i++) begin
			tx_lpi_out[i] = (tx_reg[i] != TX_ACTIVE);
			tx_refresh_out[i] = (tx_reg[i] == TX_REFRESH);
			rx_clk_stop_out[i] = rx_lpi_reg[i]
				&& (rx_cnt_reg[i] == 4'(`RX_CLK_STOP_CYC));
		end
	end
	assign rx_lpi_out = rx_lpi_reg;

	// Destination check: node address or broadcast
	logic [2:0] da_idx_reg, da_idx_next;
	logic da_mac_reg, da_mac_next, da_bc_reg, da_bc_next;
	logic frame_ok, pkt_hit;
	always_comb begin
		da_idx_next = da_idx_reg;
		da_mac_next = da_mac_reg;
		da_bc_next = da_bc_reg;
		if (rx_byte_in.valid && rx_byte_in.sof) begin
			da_idx_next = 3'd1;
			da_mac_next = (rx_byte_in.data == mac_byte(node_mac_in, 3'd0));
			da_bc_next = (rx_byte_in.data == `SYNC_BYTE);
		end else if (rx_byte_in.valid && da_idx_reg != `DA_BYTES) begin
			da_idx_next = da_idx_reg + 3'd1;
			da_mac_next = da_mac_reg && (rx_byte_in.data == mac_byte(node_mac_in, da_idx_reg));
			da_bc_next = da_bc_reg && (rx_byte_in.data == `SYNC_BYTE);
		end
	end
	assign frame_ok = (da_idx_reg == `DA_BYTES) && (da_mac_reg || da_bc_reg);

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			da_idx_reg <= 3'd0;
			da_mac_reg <= 1'b0;
			da_bc_reg <= 1'b0;
		end else begin
			da_idx_reg <= da_idx_next;
			da_mac_reg <= da_mac_next;
			da_bc_reg <= da_bc_next;
		end
	end

	wake_pkt_matcher u_matcher (
		.sys_clk_in(sys_clk_in),
		.arst_n_in(arst_n_in),
		.scan_en_in(wake_en_in.pkt && normal),
		.rx_in(rx_byte_in),
		.node_mac_in(node_mac_in),
		.hit_out(pkt_hit)
	);

	// Wake events into sticky status, set wins over clear except on a soft exit, which clears all
	logic [EEE_PORTS-1:0] link_prev_reg;
	wake_evt_t evt, stat_reg, stat_next;
	logic power_event_out_n_reg, power_event_out_n_next, int_n_reg, int_n_next;
	always_comb begin
		evt.energy = wake_en_in.energy && any_energy && (run_reg == wake_energy_cyc_in)
			&& (run_reg != 16'hffff);
		evt.link_up = wake_en_in.link_up && |(link_up_in & ~link_prev_reg);
		evt.pkt = pkt_hit && frame_ok;
		stat_next = soft_exit ? wake_evt_t'('0) : ((stat_reg & ~wake_clr_in) | evt);
		power_event_out_n_next = !(pme_en_in && |stat_next);
		int_n_next = !(int_en_in && |stat_next);
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			link_prev_reg <= '0;
			stat_reg <= '0;
			power_event_out_n_reg <= 1'b1;
			int_n_reg <= 1'b1;
		end else begin
			link_prev_reg <= link_up_in;
			stat_reg <= stat_next;
			power_event_out_n_reg <= power_event_out_n_next;
			int_n_reg <= int_n_next;
		end
	end

	assign wake_status_out = stat_reg;
	assign power_event_out_n = power_event_out_n_reg;
	assign host_interrupt_out_n = int_n_reg;
endmodule : switch_power_mgmt_wake

// *** verif/pwr_asserts.sv ***
// Concurrent checks on the ports of the power and wake controller
`timescale 1ns/1ps
module pwr_asserts import pwr_pkg::*; #(
	parameter int PORTS = 7,
	parameter int EEE_PORTS = 5
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic ctrl_wr_in,
	input wire logic [7:0] ctrl_wdata_in,
	input wire logic [EEE_PORTS-1:0] link_up_in,
	input wire logic [PORTS-1:0] port_pwrdn_in,
	input wire logic [EEE_PORTS-1:0] eee_en_in,
	input wire logic [EEE_PORTS-1:0] an_eee_ok_in,
	input wire logic [EEE_PORTS-1:0] mac_tx_lpi_req_in,
	input wire logic [EEE_PORTS-1:0] rx_code_valid_in,
	input wire logic [EEE_PORTS-1:0] rx_pcode_in,
	input wire wake_evt_t wake_en_in,
	input wire logic pme_en_in,
	input wire logic int_en_in,
	input wire pwr_mode_t mode_out,
	input wire logic energy_detect_powerdown_low_out,
	input wire logic pll_en_out,
	input wire logic mac_en_out,
	input wire logic energy_det_en_out,
	input wire logic [PORTS-1:0] port_en_out,
	input wire logic link_pulse_out,
	input wire logic soft_reset_out,
	input wire logic [EEE_PORTS-1:0] eee_active_out,
	input wire logic [EEE_PORTS-1:0] tx_lpi_out,
	input wire logic [EEE_PORTS-1:0] tx_refresh_out,
	input wire logic [EEE_PORTS-1:0] rx_lpi_out,
	input wire logic [EEE_PORTS-1:0] rx_clk_stop_out,
	input wire wake_evt_t wake_status_out,
	input wire logic power_event_out_n,
	input wire logic host_interrupt_out_n
);
	// All checks share the one clock and its reset
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);
	chk_mode_legal: assert property (mode_out != 2'h3)
		else $error("mode holds the unused code");
	chk_mode_write: assert property (ctrl_wr_in && mode_out != PM_SOFT_PD
		&& ctrl_wdata_in[4:3] != 2'h3 |=> mode_out == $past(ctrl_wdata_in[4:3]))
		else $error("mode write not taken");
	chk_clk_gate: assert property (pll_en_out == (mode_out == PM_NORMAL)
		&& mac_en_out == pll_en_out) else $error("clock or MAC enable wrong");
	chk_low_state: assert property (energy_detect_powerdown_low_out |->
		mode_out == PM_ENERGY_DETECT_POWERDOWN && energy_det_en_out && port_en_out == '0)
		else $error("low substate outside energy detect");
	chk_pulse_low: assert property (link_pulse_out
		|-> energy_detect_powerdown_low_out) else $error("link pulse outside low substate");
	chk_soft_off: assert property (mode_out == PM_SOFT_PD |-> !mac_en_out
		&& !energy_det_en_out && port_en_out == '0) else $error("block alive in soft pd");
	chk_soft_exit: assert property (mode_out == PM_SOFT_PD && ctrl_wr_in
		&& ctrl_wdata_in[4:3] inside {2'h0, 2'h1} |=> mode_out == PM_NORMAL ##[0:1] soft_reset_out)
		else $error("soft exit without reset pulse");
	chk_port_down: assert property ((port_en_out & port_pwrdn_in) == '0)
		else $error("powered down port enabled");
	chk_eee_gate: assert property ((eee_active_out
		& ~(eee_en_in & an_eee_ok_in)) == '0) else $error("EEE active without enable and agreement");
	chk_tx_follow: assert property (((tx_lpi_out | tx_refresh_out)
		& ~$past(mac_tx_lpi_req_in)) == '0) else $error("tx idle without request");
	chk_rx_enter: assert property (rx_code_valid_in[1] && rx_pcode_in[1]
		&& eee_active_out[1] |=> rx_lpi_out[1]) else $error("refresh code ignored");
	chk_rx_exit: assert property (rx_code_valid_in[1] && !rx_pcode_in[1]
		|=> !rx_lpi_out[1]) else $error("rx idle kept after data code");
	chk_rx_clk_hold: assert property (rx_clk_stop_out[1] |->
		rx_lpi_out[1] && $past(rx_lpi_out[1], 9)) else $error("rx clock stopped early");
	// Pins are registered from the next status, so they move with the status register
	chk_event_pins: assert property (power_event_out_n == !($past(pme_en_in)
		&& wake_status_out != 3'h0) && host_interrupt_out_n == !($past(int_en_in)
		&& wake_status_out != 3'h0)) else $error("event pin wrong");
	chk_link_wake: assert property ($rose(link_up_in[2]) && wake_en_in.link_up
		|-> ##[1:2] wake_status_out.link_up) else $error("link-up wake missed");
endmodule : pwr_asserts

bind switch_power_mgmt_wake pwr_asserts #(.PORTS(PORTS), .EEE_PORTS(EEE_PORTS)) i_pwr_asserts (.*);

// *** verif/link_partner_model.sv ***
// Cable link partner that sends one received frame carrying a wake sequence
`timescale 1ns/1ps
module link_partner_model import pwr_pkg::*; (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [4:0] copies_in,
	input wire logic [47:0] mac_in,
	output rx_byte_t rx_out,
	output logic busy_out
);
	int idx = -1;
	int last;
	logic tgl = 1'h0;
	logic [7:0] b;
	// Broadcast DA, two filler bytes, sync run, address copies, one trailer byte
	always_comb begin
		last = 14 + 6 * int'(copies_in);
		if (idx < 6 || (idx >= 8 && idx < 14)) begin
			b = 8'hff;
		end else if (idx >= 14 && idx < last) begin
			b = 8'(mac_in >> (8 * (5 - (idx - 14) % 6)));
		end else begin
			b = 8'h00;
		end
	end
	// Byte counter; idle data toggles so no stale byte lingers
	always @(posedge clk_in) begin
		tgl <= ~tgl;
		if (go_in) begin
			idx <= 0;
		end else if (idx >= 0 && idx < last) begin
			idx <= idx + 1;
		end else begin
			idx <= -1;
		end
	end
	assign busy_out = idx >= 0;
	assign rx_out = {idx == 0, busy_out, busy_out ? b : {8{tgl}}};
endmodule : link_partner_model

// *** verif/tb_top.sv ***
// Self-checking bench for the power and wake controller
`timescale 1ns/1ps
module tb_top import pwr_pkg::*;;
	logic sys_clk_in, arst_n_in, ctrl_wr_in, pme_en_in, int_en_in, go, busy;
	logic [7:0] ctrl_wdata_in, strap_in, strap_out;
	logic [15:0] quiet_us_in, wake_energy_cyc_in;
	logic [4:0] cable_energy_in, link_up_in, eee_en_in, an_eee_ok_in, mac_tx_lpi_req_in;
	logic [4:0] rx_code_valid_in, rx_pcode_in, eee_active_out, tx_lpi_out, tx_refresh_out;
	logic [4:0] rx_lpi_out, rx_clk_stop_out, copies;
	logic [6:0] port_pwrdn_in, port_en_out;
	logic [47:0] node_mac_in;
	logic energy_detect_powerdown_low_out, pll_en_out, mac_en_out, energy_det_en_out;
	logic link_pulse_out, soft_reset_out, power_event_out_n, host_interrupt_out_n;
	rx_byte_t rx_byte_in;
	wake_evt_t wake_en_in, wake_clr_in, wake_status_out;
	pwr_mode_t mode_out;
	int miscompares = 0;
	int total_checks = 0;
	int i;
	switch_power_mgmt_wake #(.REFRESH_PERIOD_CYC(64), .REFRESH_LEN_CYC(16),
		.LINK_PULSE_CYC(32)) i_switch_power_mgmt_wake (.*);
	link_partner_model i_link_partner_model (.clk_in(sys_clk_in), .go_in(go),
		.copies_in(copies), .mac_in(node_mac_in), .rx_out(rx_byte_in), .busy_out(busy));
	// Clock at 8 ns
	initial begin
		sys_clk_in = 1'h0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	task automatic give_verdict;
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : tick
	task automatic wr_mode(input logic [1:0] m);
		@(posedge sys_clk_in);
		ctrl_wr_in <= 1'h1;
		ctrl_wdata_in <= {3'h0, m, 3'h0};
		@(posedge sys_clk_in);
		ctrl_wr_in <= 1'h0;
		#1;
	endtask : wr_mode
	task automatic send(input logic [4:0] n);
		@(posedge sys_clk_in);
		go <= 1'h1;
		copies <= n;
		@(posedge sys_clk_in);
		go <= 1'h0;
		tick(1);
		for (i = 0; i < 200 && busy !== 1'h0; i++) tick(1);
		tick(4);
	endtask : send
	task automatic t_modes;
		wr_mode(2'h1); // Auto-negotiation stays on meanwhile
		check("mode_ed", mode_out, PM_ENERGY_DETECT_POWERDOWN);
		check("ed_en", {pll_en_out, energy_det_en_out}, 2'h1);
		wr_mode(2'h3);
		check("mode_rsvd", mode_out, PM_ENERGY_DETECT_POWERDOWN);
		wr_mode(2'h0);
		check("mode_norm", mode_out, PM_NORMAL);
		check("run_en", {pll_en_out, mac_en_out, energy_det_en_out}, 3'h6);
	endtask : t_modes
	task automatic t_energy_detect_powerdown;
		wr_mode(2'h1);
		for (i = 0; i < 600 && energy_detect_powerdown_low_out !== 1'h1; i++) tick(1);
		check("low", {energy_detect_powerdown_low_out, port_en_out}, 8'h80);
		for (i = 0; i < 40 && link_pulse_out !== 1'h1; i++) tick(1);
		check("pulse", link_pulse_out, 1'h1);
		@(posedge sys_clk_in);
		cable_energy_in <= 5'h01;
		// Two sync stages plus thirteen counted cycles: the 100ns count is just met, exit comes on the next edge
		tick(15);
		check("early", energy_detect_powerdown_low_out, 1'h1);
		for (i = 0; i < 20 && energy_detect_powerdown_low_out !== 1'h0; i++) tick(1);
		check("full", energy_detect_powerdown_low_out, 1'h0);
		@(posedge sys_clk_in);
		port_pwrdn_in <= 7'h41;
		tick(1);
		check("port_ed", port_en_out, 7'h3e);
		wr_mode(2'h0);
		check("port_norm", port_en_out, 7'h3e);
		@(posedge sys_clk_in);
		port_pwrdn_in <= 7'h00;
	endtask : t_energy_detect_powerdown
	task automatic t_eee;
		@(posedge sys_clk_in);
		eee_en_in <= 5'h1f;
		an_eee_ok_in <= 5'h0f;
		tick(1);
		check("eee", eee_active_out, 5'h0f);
		@(posedge sys_clk_in);
		rx_code_valid_in <= 5'h02;
		rx_pcode_in <= 5'h02;
		mac_tx_lpi_req_in <= 5'h1f;
		@(posedge sys_clk_in);
		rx_code_valid_in <= 5'h00;
		tick(1);
		check("tx_lpi", tx_lpi_out, 5'h0f);
		check("rx_lpi", {rx_lpi_out, rx_clk_stop_out}, 10'h040);
		tick(11);
		check("rx_clk_stop", rx_clk_stop_out, 5'h02);
		for (i = 0; i < 80 && tx_refresh_out[0] !== 1'h1; i++) tick(1);
		for (i = 0; i < 40 && tx_refresh_out[0] === 1'h1; i++) tick(1);
		check("refresh_len", i, 16);
		@(posedge sys_clk_in);
		mac_tx_lpi_req_in <= 5'h1e;
		tick(2);
		check("tx_drop", {tx_lpi_out[0], tx_refresh_out[0], tx_lpi_out[1]}, 3'h1);
		check("rx_kept", rx_lpi_out, 5'h02);
		@(posedge sys_clk_in);
		rx_code_valid_in <= 5'h02;
		rx_pcode_in <= 5'h00;
		@(posedge sys_clk_in);
		rx_code_valid_in <= 5'h00;
		mac_tx_lpi_req_in <= 5'h00;
		tick(1);
		check("rx_exit", rx_lpi_out, 5'h00);
	endtask : t_eee
	task automatic t_wake;
		@(posedge sys_clk_in);
		wake_en_in <= 3'h7;
		pme_en_in <= 1'h1;
		cable_energy_in <= 5'h00;
		wake_clr_in <= 3'h7;
		@(posedge sys_clk_in);
		wake_clr_in <= 3'h0;
		send(5'h0f);
		check("pkt_short", wake_status_out, 3'h0);
		send(5'h10);
		check("pkt_hit", wake_status_out, 3'h4);
		check("pme", {power_event_out_n, host_interrupt_out_n}, 2'h1);
		@(posedge sys_clk_in);
		wake_clr_in <= 3'h4;
		int_en_in <= 1'h1;
		link_up_in <= 5'h04;
		@(posedge sys_clk_in);
		wake_clr_in <= 3'h0;
		tick(3);
		check("link", wake_status_out, 3'h2);
		check("int", {power_event_out_n, host_interrupt_out_n}, 2'h0);
		@(posedge sys_clk_in);
		wake_clr_in <= 3'h2;
		pme_en_in <= 1'h0;
		cable_energy_in <= 5'h01;
		@(posedge sys_clk_in);
		wake_clr_in <= 3'h0;
		tick(10);
		check("energy_early", wake_status_out, 3'h0);
		tick(20);
		check("energy", wake_status_out, 3'h1);
		check("pins", {power_event_out_n, host_interrupt_out_n}, 2'h2);
	endtask : t_wake
	task automatic t_soft;
		@(posedge sys_clk_in);
		strap_in <= 8'h5a;
		wr_mode(2'h2);
		check("soft", {mac_en_out, port_en_out}, 8'h00);
		check("soft_stat_kept", wake_status_out, 3'h1);
		wr_mode(2'h1);
		check("soft_exit", mode_out, PM_NORMAL);
		check("straps", strap_out, 8'h5a);
		check("soft_stat", wake_status_out, 3'h0);
		for (i = 0; i < 3 && soft_reset_out !== 1'h1; i++) tick(1);
		check("soft_rst", soft_reset_out, 1'h1);
	endtask : t_soft
	// Main sequence: reset, then each scenario in turn
	initial begin
		{arst_n_in, ctrl_wr_in, pme_en_in, int_en_in, go} = 5'h00;
		{ctrl_wdata_in, strap_in, copies} = 21'h0;
		{cable_energy_in, link_up_in, eee_en_in, an_eee_ok_in} = 20'h0;
		{mac_tx_lpi_req_in, rx_code_valid_in, rx_pcode_in, port_pwrdn_in} = 22'h0;
		{wake_en_in, wake_clr_in} = 6'h0;
		quiet_us_in = 16'h0001;
		wake_energy_cyc_in = 16'h0014;
		node_mac_in = 48'h0a1b2c3d4e5f;
		repeat (10) @(posedge sys_clk_in);
		arst_n_in <= 1'h1;
		tick(1);
		check("rst_mode", mode_out, PM_NORMAL);
		check("rst_eee", {eee_active_out, wake_status_out}, 8'h00);
		check("rst_pins", {power_event_out_n, host_interrupt_out_n}, 2'h3);
		t_modes();
		t_energy_detect_powerdown();
		t_eee();
		t_wake();
		t_soft();
		give_verdict();
	end
	// Watchdog against a hung scenario
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		miscompares++;
		give_verdict();
	end
endmodule : tb_top
